// *** rtl/bcm_pkg.sv ***
package bcm_pkg;

    // ------------------------------------------------------------------
    // register map (word offsets in bytes)
    // ------------------------------------------------------------------
    localparam logic [5:0] OFF_A_ADDR = 6'h00;
    localparam logic [5:0] OFF_A_AMASK = 6'h04;
    localparam logic [5:0] OFF_A_CYC = 6'h08;
    localparam logic [5:0] OFF_B_ADDR = 6'h0c;
    localparam logic [5:0] OFF_B_AMASK = 6'h10;
    localparam logic [5:0] OFF_B_CYC = 6'h14;
    localparam logic [5:0] OFF_B_DATA = 6'h18;
    localparam logic [5:0] OFF_B_DMASK = 6'h1c;
    localparam logic [5:0] OFF_CTRL = 6'h20;
    localparam logic [5:0] OFF_STATUS = 6'h24;
    localparam logic [5:0] OFF_IMASK = 6'h28;

    // ------------------------------------------------------------------
    // cycle select fields
    // ------------------------------------------------------------------
    localparam int CS_EN = 0;
    localparam int CS_FETCH = 1;
    localparam int CS_DATA = 2;
    localparam int CS_RD = 3;
    localparam int CS_WR = 4;
    localparam int CS_SZ_LO = 5;
    localparam int CS_SZ_HI = 6;
    localparam int CS_PBUS = 7;
    localparam int CS_POST = 8;
    localparam int CS_DCMP = 9;
    localparam int CS_TAG_EN = 10;
    localparam int CS_TAG_LO = 16;
    localparam int CS_TAG_HI = 23;
    localparam logic [31:0] CS_WMASK = 32'h00ff07ff;

    // control fields
    localparam int CTL_SEQ = 0;
    localparam int CTL_STBY = 1;

    // status fields
    localparam int ST_FLAG_A = 0;
    localparam int ST_FLAG_B = 1;

    localparam logic [1:0] SZ_ANY = 2'h0;
    localparam logic [1:0] SZ_BYTE = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [1:0] SZ_LONG = 2'h3;

    // one observed bus cycle
    typedef struct packed {
        logic valid;
        logic fetch;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] data;
        logic [7:0] space_tag;
    } bcm_cycle_t;

    // core exception context for the instruction owning the match
    typedef struct packed {
        logic hi_reexec;
        logic hi_trap;
        logic addr_err;
        logic ret_slot;
        logic ret_target;
    } bcm_exc_t;

    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b00,
        SEQ_ARMED = 2'b01
    } bcm_seq_t;

endpackage : bcm_pkg

// *** rtl/bcm_break_matcher.sv ***
// Functional notes
// - size-free read matches any access whose footprint covers target
// - address mask ones remove those address bits from compare
// - data+size compare breaks only on exact size and data match
// - data mask ones remove those data bits from compare
// - peripheral-bus fetch at exact address raises break
// - new register values take effect before write answer completes
// - each channel watches exactly one bus, chosen per channel
// - sequential: channel b must match in a later cycle than a
// - higher exception suppresses break; pre-execution break outranks all
// - re-execution exception wins over post break, flag stays clear
// - trap wins over post break, yet match flag is set
// - data address error wins, yet match flag is set
// - pre-execution break in return delay slot deferred to target
// - in module standby no breaks are generated
// - pre-execution break suppresses matched instruction, saves its pc
`timescale 1ns/1ps
module bcm_break_matcher
    import bcm_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire bcm_cycle_t lbus_cycle,
    input wire bcm_cycle_t pbus_cycle,
    input wire logic [31:0] lbus_pc,
    input wire logic [31:0] pbus_pc,
    input wire bcm_exc_t core_exc,
    output logic break_req,
    output logic break_pre,
    output logic [31:0] break_pc,
    output logic irq
);

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    logic [31:0] a_addr, a_amask, a_cyc, b_addr, b_amask, b_cyc;
    logic [31:0] b_data, b_dmask, ctrl, status, imask;
    logic [31:0] next_a_addr, next_a_amask, next_a_cyc, next_b_addr;
    logic [31:0] next_b_amask, next_b_cyc, next_b_data, next_b_dmask;
    logic [31:0] next_ctrl, next_status, next_imask, next_readdata;
    logic next_waitrequest, next_irq;
    logic pending;
    logic next_pending;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // ------------------------------------------------------------------
    // channel compare
    // ------------------------------------------------------------------
    function automatic logic chan_hit(input bcm_cycle_t c,
                                      input logic [31:0] ma,
                                      input logic [31:0] mm,
                                      input logic [31:0] cs,
                                      input logic [31:0] md,
                                      input logic [31:0] dm);
        logic [31:0] lo;
        logic [31:0] hi;
        logic [31:0] tgt;
        logic ok;
        logic [1:0] sz;
        sz = cs[CS_SZ_HI:CS_SZ_LO];
        ok = c.valid && cs[CS_EN];
        ok = ok && ((c.fetch && cs[CS_FETCH]) || (!c.fetch && cs[CS_DATA]));
        ok = ok && ((c.write && cs[CS_WR]) || (!c.write && cs[CS_RD]));
        ok = ok && (!cs[CS_TAG_EN] || c.space_tag == cs[CS_TAG_HI:CS_TAG_LO]);
        if (sz == SZ_ANY)
        begin
            // footprint covers target after masking
            lo = c.addr & ~mm;
            tgt = ma & ~mm;
            case (c.size)
                SZ_LONG: lo = lo & 32'hfffffffc;
                SZ_WORD: lo = lo & 32'hfffffffe;
                default: lo = lo;
            endcase
            case (c.size)
                SZ_LONG: hi = lo + 32'h00000003;
                SZ_WORD: hi = lo + 32'h00000001;
                default: hi = lo;
            endcase
            ok = ok && (tgt >= lo) && (tgt <= hi);
        end
        else
        begin
            ok = ok && (c.size == sz);
            ok = ok && ((c.addr & ~mm) == (ma & ~mm));
        end
        if (cs[CS_DCMP])
        begin
            ok = ok && ((c.data & ~dm) == (md & ~dm));
        end
        return ok;
    endfunction : chan_hit

    logic hit_a, hit_b, post_a, post_b, pre_sel;
    bcm_cycle_t cyc_a, cyc_b;
    logic [31:0] pc_a, pc_b;

    // each channel takes one bus only
    always_comb
    begin
        cyc_a = a_cyc[CS_PBUS] ? pbus_cycle : lbus_cycle;
        cyc_b = b_cyc[CS_PBUS] ? pbus_cycle : lbus_cycle;
        pc_a = a_cyc[CS_PBUS] ? pbus_pc : lbus_pc;
        pc_b = b_cyc[CS_PBUS] ? pbus_pc : lbus_pc;
        // channel a never compares data
        hit_a = chan_hit(cyc_a, a_addr, a_amask, a_cyc & ~(32'h1 << CS_DCMP),
                         32'h00000000, 32'hffffffff);
        hit_b = chan_hit(cyc_b, b_addr, b_amask, b_cyc, b_data, b_dmask);
        post_a = a_cyc[CS_POST] || !cyc_a.fetch;
        post_b = b_cyc[CS_POST] || !cyc_b.fetch;
    end

    // ------------------------------------------------------------------
    // sequencing and priority
    // ------------------------------------------------------------------
    bcm_seq_t seq_state, next_seq_state;
    logic [1:0] defer;
    logic [1:0] next_defer;
    logic next_break_req, next_break_pre;
    logic [31:0] next_break_pc;

    always_comb
    begin
        logic ev_a;
        logic ev_b;
        logic fire;
        logic is_pre;
        logic set_a;
        logic set_b;
        logic [31:0] pc;
        ev_a = 1'b0;
        ev_b = 1'b0;
        fire = 1'b0;
        is_pre = 1'b0;
        set_a = 1'b0;
        set_b = 1'b0;
        pc = 32'h00000000;
        next_seq_state = seq_state;
        next_defer = defer;
        if (ctrl[CTL_STBY])
        begin
            // standby: nothing fires, sequence forgotten
            next_seq_state = SEQ_IDLE;
            next_defer = 2'b00;
        end
        else if (ctrl[CTL_SEQ])
        begin
            // a must precede b in an earlier cycle
            ev_b = hit_b && (seq_state == SEQ_ARMED);
            if (hit_a && seq_state == SEQ_IDLE)
            begin
                next_seq_state = SEQ_ARMED;
            end
            if (ev_b)
            begin
                next_seq_state = SEQ_IDLE;
            end
        end
        else
        begin
            ev_a = hit_a;
            ev_b = hit_b;
        end
        // return delay slot pre breaks wait for its target
        if (core_exc.ret_slot)
        begin
            if (ev_a && !post_a)
            begin
                next_defer[0] = 1'b1;
                ev_a = 1'b0;
            end
            if (ev_b && !post_b)
            begin
                next_defer[1] = 1'b1;
                ev_b = 1'b0;
            end
        end
        else if (core_exc.ret_target && defer != 2'b00 && !ctrl[CTL_STBY])
        begin
            ev_a = ev_a || defer[0];
            ev_b = ev_b || defer[1];
            next_defer = 2'b00;
        end
        if ((ev_a && !post_a) || (ev_b && !post_b))
        begin
            // pre break outranks every exception, pc of matched insn
            fire = 1'b1;
            is_pre = 1'b1;
            set_a = ev_a && !post_a;
            set_b = ev_b && !post_b;
            pc = (ev_a && !post_a) ? pc_a : pc_b;
        end
        else if (ev_a || ev_b)
        begin
            pc = ev_a ? pc_a : pc_b;
            if (core_exc.addr_err)
            begin
                set_a = ev_a;
                set_b = ev_b;
            end
            else if (core_exc.hi_reexec)
            begin
                // flag waits for re-execution
                set_a = 1'b0;
                set_b = 1'b0;
            end
            else if (core_exc.hi_trap)
            begin
                set_a = ev_a;
                set_b = ev_b;
            end
            else
            begin
                fire = 1'b1;
                set_a = ev_a;
                set_b = ev_b;
            end
        end
        next_break_req = fire;
        next_break_pre = is_pre;
        next_break_pc = fire ? pc : break_pc;
        // hardware set wins over software clear
        next_status = status;
        if (avs_write && pending && avs_address == OFF_STATUS)
        begin
            next_status = status & ~merge(32'h0, avs_writedata,
                                          avs_byteenable);
        end
        next_status[ST_FLAG_A] = next_status[ST_FLAG_A] | set_a;
        next_status[ST_FLAG_B] = next_status[ST_FLAG_B] | set_b;
        next_status[31:2] = 30'h0;
    end

    // ------------------------------------------------------------------
    // bus slave: one wait cycle, write lands before the answer
    // ------------------------------------------------------------------
    always_comb
    begin
        next_pending = (avs_read || avs_write) && !pending;
        next_waitrequest = !next_pending;
        next_a_addr = a_addr;
        next_a_amask = a_amask;
        next_a_cyc = a_cyc;
        next_b_addr = b_addr;
        next_b_amask = b_amask;
        next_b_cyc = b_cyc;
        next_b_data = b_data;
        next_b_dmask = b_dmask;
        next_ctrl = ctrl;
        next_imask = imask;
        next_readdata = 32'h00000000;
        if (pending && avs_write)
        begin
            case (avs_address)
                OFF_A_ADDR: next_a_addr = merge(a_addr, avs_writedata,
                                                avs_byteenable);
                OFF_A_AMASK: next_a_amask = merge(a_amask, avs_writedata,
                                                  avs_byteenable);
                OFF_A_CYC: next_a_cyc = merge(a_cyc, avs_writedata,
                                              avs_byteenable) & CS_WMASK;
                OFF_B_ADDR: next_b_addr = merge(b_addr, avs_writedata,
                                                avs_byteenable);
                OFF_B_AMASK: next_b_amask = merge(b_amask, avs_writedata,
                                                  avs_byteenable);
                OFF_B_CYC: next_b_cyc = merge(b_cyc, avs_writedata,
                                              avs_byteenable) & CS_WMASK;
                OFF_B_DATA: next_b_data = merge(b_data, avs_writedata,
                                                avs_byteenable);
                OFF_B_DMASK: next_b_dmask = merge(b_dmask, avs_writedata,
                                                  avs_byteenable);
                OFF_CTRL: next_ctrl = merge(ctrl, avs_writedata,
                                            avs_byteenable) & 32'h00000003;
                OFF_IMASK: next_imask = merge(imask, avs_writedata,
                                              avs_byteenable) & 32'h00000003;
                default: next_ctrl = ctrl;
            endcase
        end
        if (next_pending && avs_read)
        begin
            // no standby gating here: software must not rely on the contents
            case (avs_address)
                OFF_A_ADDR: next_readdata = a_addr;
                OFF_A_AMASK: next_readdata = a_amask;
                OFF_A_CYC: next_readdata = a_cyc;
                OFF_B_ADDR: next_readdata = b_addr;
                OFF_B_AMASK: next_readdata = b_amask;
                OFF_B_CYC: next_readdata = b_cyc;
                OFF_B_DATA: next_readdata = b_data;
                OFF_B_DMASK: next_readdata = b_dmask;
                OFF_CTRL: next_readdata = ctrl;
                OFF_STATUS: next_readdata = status;
                OFF_IMASK: next_readdata = imask;
                default: next_readdata = 32'h00000000;
            endcase
        end
        next_irq = |(next_status & imask);
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            a_addr <= 32'h00000000;
            a_amask <= 32'h00000000;
            a_cyc <= 32'h00000000;
            b_addr <= 32'h00000000;
            b_amask <= 32'h00000000;
            b_cyc <= 32'h00000000;
            b_data <= 32'h00000000;
            b_dmask <= 32'h00000000;
            ctrl <= 32'h00000000;
            status <= 32'h00000000;
            imask <= 32'h00000000;
            pending <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            seq_state <= SEQ_IDLE;
            defer <= 2'b00;
            break_req <= 1'b0;
            break_pre <= 1'b0;
            break_pc <= 32'h00000000;
            irq <= 1'b0;
        end
        else
        begin
            a_addr <= next_a_addr;
            a_amask <= next_a_amask;
            a_cyc <= next_a_cyc;
            b_addr <= next_b_addr;
            b_amask <= next_b_amask;
            b_cyc <= next_b_cyc;
            b_data <= next_b_data;
            b_dmask <= next_b_dmask;
            ctrl <= next_ctrl;
            status <= next_status;
            imask <= next_imask;
            pending <= next_pending;
            avs_waitrequest <= next_waitrequest;
            avs_readdata <= next_readdata;
            seq_state <= next_seq_state;
            defer <= next_defer;
            break_req <= next_break_req;
            break_pre <= next_break_pre;
            break_pc <= next_break_pc;
            irq <= next_irq;
        end
    end

endmodule : bcm_break_matcher

// *** verification/bcm_break_matcher_properties.sv ***
`timescale 1ns/1ps
module bcm_break_matcher_checker
    import bcm_pkg::*;
(
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    input wire bcm_cycle_t lbus_cycle,
    input wire bcm_cycle_t pbus_cycle,
    input wire logic [31:0] lbus_pc,
    input wire logic [31:0] pbus_pc,
    input wire bcm_exc_t core_exc,
    input wire logic break_req,
    input wire logic break_pre,
    input wire logic [31:0] break_pc
);
    // ------------------------------------------------------------------
    // standby copy, rebuilt from completed control writes
    // ------------------------------------------------------------------
    logic stby;
    logic next_stby;
    always_comb
    begin
        next_stby = stby;
        if (avs_write && !avs_waitrequest && avs_address == OFF_CTRL
            && avs_byteenable[0])
        begin
            next_stby = avs_writedata[CTL_STBY];
        end
        if (sys_rst)
        begin
            next_stby = 1'b0;
        end
    end
    always_ff @(posedge mclk)
    begin
        stby <= next_stby;
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    a_req_has_cause: assert property (
        break_req |-> $past(lbus_cycle.valid || pbus_cycle.valid))
        else $error("break request without a bus cycle");
    a_standby_quiet: assert property (
        $past(stby) |-> !break_req)
        else $error("break request during standby");
    a_one_wait: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not answered after one wait");
    a_idle_wait: assert property (
        !(avs_read || avs_write) |=> avs_waitrequest)
        else $error("waitrequest low without a request");
    a_pre_on_fetch: assert property (
        break_req && break_pre |-> $past(lbus_cycle.valid
        && lbus_cycle.fetch || pbus_cycle.valid && pbus_cycle.fetch))
        else $error("pre-execution break not on a fetch");
    a_pc_saved: assert property (
        break_req && break_pre && $past(lbus_cycle.valid != pbus_cycle.valid)
        |-> break_pc == $past(lbus_cycle.valid ? lbus_pc : pbus_pc))
        else $error("saved pc is not the matched fetch");
    a_pc_held: assert property (
        !break_req && !$past(sys_rst) |-> $stable(break_pc))
        else $error("saved pc moved without a break");
    a_exc_wins: assert property (
        break_req && $past(core_exc.hi_trap || core_exc.hi_reexec
        || core_exc.addr_err) |-> break_pre)
        else $error("post break taken over a higher exception");
endmodule : bcm_break_matcher_checker

bind bcm_break_matcher bcm_break_matcher_checker u_chk (.mclk, .sys_rst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_waitrequest, .lbus_cycle, .pbus_cycle, .lbus_pc, .pbus_pc,
    .core_exc, .break_req, .break_pre, .break_pc);

// *** verification/bcm_core_model.sv ***
`timescale 1ns/1ps
module bcm_core_model
    import bcm_pkg::*;
(
    input wire logic mclk,
    output bcm_cycle_t lbus_cycle,
    output bcm_cycle_t pbus_cycle,
    output logic [31:0] lbus_pc,
    output logic [31:0] pbus_pc,
    output bcm_exc_t core_exc
);
    initial
    begin
        lbus_cycle = '0;
        pbus_cycle = '0;
        lbus_pc = '0;
        pbus_pc = '0;
        core_exc = '0;
    end
    // one bus per call; idle buses show a flipped copy so stale fields
    // can never pass for a live cycle
    task automatic issue(input logic on_p, input bcm_cycle_t c,
        input logic [31:0] pc, input bcm_exc_t e);
        bcm_cycle_t idle;
        idle = ~c;
        idle.valid = 1'b0;
        @(posedge mclk);
        if (on_p)
        begin
            pbus_cycle <= c;
            pbus_pc <= pc;
        end
        else
        begin
            lbus_cycle <= c;
            lbus_pc <= pc;
        end
        core_exc <= e;
        @(posedge mclk);
        lbus_cycle <= idle;
        pbus_cycle <= idle;
        lbus_pc <= ~pc;
        pbus_pc <= ~pc;
        core_exc <= '0;
    endtask : issue
endmodule : bcm_core_model

// *** verification/bcm_break_matcher_test.sv ***
`timescale 1ns/1ps
module bcm_break_matcher_test
    import bcm_pkg::*;
;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [5:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata, lbus_pc, pbus_pc, break_pc;
    logic avs_waitrequest, break_req, break_pre, irq;
    bcm_cycle_t lbus_cycle, pbus_cycle;
    bcm_exc_t core_exc;
    logic [1:0] im = 2'h0;
    int err_total = 0;
    int comparisons = 0;
    always #20 mclk = ~mclk;
    bcm_break_matcher dut (.mclk, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
        .avs_waitrequest, .lbus_cycle, .pbus_cycle, .lbus_pc, .pbus_pc,
        .core_exc, .break_req, .break_pre, .break_pc, .irq);
    bcm_core_model core (.mclk, .lbus_cycle, .pbus_cycle, .lbus_pc,
        .pbus_pc, .core_exc);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
        begin
            $display("RESULT: PASS");
        end
        else
        begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic do_reset;
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
    endtask : do_reset
    // waits on waitrequest; only the bench watchdog ends a dead slave
    task automatic acc(input logic w, input logic [5:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        do
        begin
            @(posedge mclk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : acc
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        acc(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        acc(1'b0, a, 32'h0, q);
        check($sformatf("reg %h", a), q, exp);
    endtask : rd
    function automatic bcm_cycle_t mk(logic f, logic w, logic [1:0] s,
        logic [31:0] a, logic [31:0] d);
        return '{1'b1, f, w, s, a, d, 8'h00};
    endfunction : mk
    task automatic cfg(input logic [31:0] aa, am, ac, ba, bm, bc, bd, bk,
        input logic [31:0] ctl);
        wr(OFF_A_ADDR, aa);
        wr(OFF_A_AMASK, am);
        wr(OFF_A_CYC, ac);
        wr(OFF_B_ADDR, ba);
        wr(OFF_B_AMASK, bm);
        wr(OFF_B_CYC, bc);
        wr(OFF_B_DATA, bd);
        wr(OFF_B_DMASK, bk);
        wr(OFF_CTRL, ctl);
        rd(OFF_CTRL, ctl);
    endtask : cfg
    task automatic pulse(input logic p, input bcm_cycle_t c,
        input logic [31:0] pc, input bcm_exc_t e, input logic x);
        core.issue(p, c, pc, e);
        @(negedge mclk);
        check("break_req", 32'(break_req), 32'(x));
    endtask : pulse
    task automatic hit(input logic p, input bcm_cycle_t c,
        input logic [31:0] pc, input bcm_exc_t e, input logic x,
        input logic [1:0] fl);
        pulse(p, c, pc, e, x);
        rd(OFF_STATUS, 32'(fl));
        check("irq", 32'(irq), 32'(|(fl & im)));
        wr(OFF_STATUS, 32'h3);
    endtask : hit
    // ------------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------------
    initial
    begin
        bcm_cycle_t f;
        f = mk(1'b1, 1'b0, SZ_WORD, 32'h00314156, 32'h0);
        do_reset();
        rd(6'h2c, 32'h0);
        im = 2'h3;
        wr(OFF_IMASK, 32'h3);
        cfg(32'h00123456, 32'h0, 32'h0d, 32'h000abcde, 32'hff, 32'h255,
            32'ha512, 32'h0, 32'h0);
        hit(0, mk(0, 0, SZ_LONG, 32'h00123454, 0), 1, 0, 1, 1);
        hit(0, mk(0, 0, SZ_WORD, 32'h00123456, 0), 1, 0, 1, 1);
        hit(0, mk(0, 0, SZ_BYTE, 32'h00123456, 0), 1, 0, 1, 1);
        hit(0, mk(0, 0, SZ_WORD, 32'h00123454, 0), 1, 0, 0, 0);
        hit(0, mk(0, 1, SZ_WORD, 32'h000abc00, 32'ha512), 1, 0, 1, 2);
        hit(0, mk(0, 1, SZ_WORD, 32'h000abcfe, 32'ha512), 1, 0, 1, 2);
        hit(0, mk(0, 1, SZ_WORD, 32'h000abd00, 32'ha512), 1, 0, 0, 0);
        hit(0, mk(0, 1, SZ_WORD, 32'h000abc10, 32'ha513), 1, 0, 0, 0);
        hit(0, mk(0, 1, SZ_BYTE, 32'h000abc10, 32'ha512), 1, 0, 0, 0);
        hit(0, mk(0, 0, SZ_WORD, 32'h00123456, 0), 1, 5'h08, 0, 1);
        hit(0, mk(0, 0, SZ_WORD, 32'h00123456, 0), 1, 5'h04, 0, 1);
        hit(0, mk(0, 0, SZ_WORD, 32'h00123456, 0), 1, 5'h10, 0, 0);
        hit(0, mk(0, 0, SZ_WORD, 32'h00123456, 0), 1, 0, 1, 1);
        im = 2'h1;
        wr(OFF_IMASK, 32'h1);
        hit(0, mk(0, 1, SZ_WORD, 32'h000abc20, 32'ha512), 1, 0, 1, 2);
        im = 2'h3;
        wr(OFF_IMASK, 32'h3);
        cfg(32'h00314156, 32'h0, 32'h8b, 32'h00055555, 32'h0, 32'h2b5,
            32'h78, 32'h0f, 32'h0);
        pulse(1, f, 32'h00314156, 0, 1);
        check("break_pre", 32'(break_pre), 32'h1);
        check("break_pc", break_pc, 32'h00314156);
        wr(OFF_STATUS, 32'h3);
        hit(0, f, 32'h00314156, 0, 0, 0);
        hit(1, mk(0, 1, SZ_BYTE, 32'h00055555, 32'h7a), 1, 0, 1, 2);
        hit(1, mk(0, 1, SZ_BYTE, 32'h00055555, 32'h68), 1, 0, 0, 0);
        hit(1, f, 32'h00314156, 5'h18, 1, 1);
        pulse(1, f, 32'h00314156, 5'h02, 0);
        hit(1, mk(1, 0, SZ_WORD, 32'h00400000, 0), 2, 5'h01, 1, 1);
        wr(OFF_CTRL, 32'h2);
        pulse(1, f, 32'h00314156, 0, 0);
        wr(OFF_CTRL, 32'h0);
        hit(1, f, 32'h00314156, 0, 1, 1);
        // sequential mode: b alone, a alone, then b after a
        do_reset();
        cfg(32'h1000, 0, 32'h0b, 32'h2000, 0, 32'h0b, 0, 0, 32'h1);
        pulse(0, mk(1, 0, SZ_WORD, 32'h2000, 0), 3, 0, 0);
        pulse(0, mk(1, 0, SZ_WORD, 32'h1000, 0), 3, 0, 0);
        pulse(0, mk(1, 0, SZ_WORD, 32'h2000, 0), 3, 0, 1);
        do_reset();
        cfg(32'h1000, 0, 32'h0b, 32'h1000, 0, 32'h0b, 0, 0, 32'h1);
        pulse(0, mk(1, 0, SZ_WORD, 32'h1000, 0), 3, 0, 0);
        report_and_stop();
    end
    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_total++;
        report_and_stop();
    end
endmodule : bcm_break_matcher_test
